// ### verilog/ltsp_pkg.sv
package ltsp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PATTERN = 8'h04;
  localparam logic [7:0] ADDR_DRIVER = 8'h08;
  localparam logic [7:0] ADDR_BOOST = 8'h0C;
  localparam logic [7:0] ADDR_LIVE = 8'h10;
  localparam logic [7:0] ADDR_ERRCNT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_MONITOR = 8'h20;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_TX_BLOCK = 0;
  localparam int CTRL_INJECT = 1;
  localparam int CTRL_CNT_CLEAR = 2;
  localparam int CTRL_EQ_RESET = 3;
  localparam int CTRL_HIGH_HOLD = 4;
  localparam int CTRL_HIGH_OVR = 5;
  localparam int CTRL_LOW_HOLD = 6;
  localparam int CTRL_LOW_OVR = 7;
  localparam int CTRL_FREEZE = 8;
  localparam int CTRL_W = 9;
  localparam int PAT_GEN_LSB = 0;
  localparam int PAT_CHK_LSB = 4;
  localparam int SEL_W = 3;
  localparam int DRV_POST_LSB = 0;
  localparam int DRV_PRE_LSB = 8;
  localparam int DRV_SWING_LSB = 16;
  localparam int EMPH_W = 5;
  localparam int SWING_W = 4;
  localparam int BOOST_HIGH_LSB = 0;
  localparam int BOOST_LOW_LSB = 8;
  localparam int BOOST_W = 5;
  localparam int PHASE_W = 7;
  localparam int IRQ_PATTERN = 0;
  localparam int IRQ_DISPARITY = 1;
  localparam int IRQ_CODE = 2;
  localparam int IRQ_COMMA = 3;
  localparam int IRQ_W = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] PATTERN_SEED = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Test pattern codes and feedback taps
  // ----------------------------------------------------------------
  localparam logic [2:0] PAT_OFF = 3'h0;
  localparam logic [2:0] PAT_P7 = 3'h1;
  localparam logic [2:0] PAT_P15 = 3'h2;
  localparam logic [2:0] PAT_P23 = 3'h3;
  localparam logic [2:0] PAT_P31 = 3'h4;
  localparam int TAP7_A = 7;
  localparam int TAP7_B = 6;
  localparam int TAP15_A = 15;
  localparam int TAP15_B = 14;
  localparam int TAP23_A = 23;
  localparam int TAP23_B = 18;
  localparam int TAP31_A = 31;
  localparam int TAP31_B = 28;

  // ----------------------------------------------------------------
  // Line symbol constants
  // ----------------------------------------------------------------
  localparam int SYM_W = 10;
  localparam logic [3:0] ONES_NEG = 4'h4;
  localparam logic [3:0] ONES_BAL = 4'h5;
  localparam logic [3:0] ONES_POS = 4'h6;
  localparam logic [6:0] COMMA_POS = 7'h1F;
  localparam logic [6:0] COMMA_NEG = 7'h60;

  function automatic logic pat_valid(input logic [2:0] sel);
    pat_valid = (sel == PAT_P7) || (sel == PAT_P15) ||
                (sel == PAT_P23) || (sel == PAT_P31);
  endfunction

  function automatic int tap_a(input logic [2:0] sel);
    case (sel)
      PAT_P15: tap_a = TAP15_A;
      PAT_P23: tap_a = TAP23_A;
      PAT_P31: tap_a = TAP31_A;
      default: tap_a = TAP7_A;
    endcase
  endfunction

  function automatic int tap_b(input logic [2:0] sel);
    case (sel)
      PAT_P15: tap_b = TAP15_B;
      PAT_P23: tap_b = TAP23_B;
      PAT_P31: tap_b = TAP31_B;
      default: tap_b = TAP7_B;
    endcase
  endfunction

  // Next 32 pattern bits; bit 0 is the earliest in time.
  function automatic logic [31:0] pat_next(input logic [31:0] prev,
                                           input logic [2:0] sel);
    logic [63:0] ext;
    int a;
    int b;
    ext = {32'h0000_0000, prev};
    a = tap_a(sel);
    b = tap_b(sel);
    for (int i = 32; i < 64; i++) begin
      ext[i] = ext[i - a] ^ ext[i - b];
    end
    pat_next = ext[63:32];
  endfunction

  // Bits of a received word that break the recurrence of the pattern.
  function automatic logic [31:0] pat_miss(input logic [31:0] prev,
                                           input logic [31:0] cur,
                                           input logic [2:0] sel);
    logic [63:0] ext;
    int a;
    int b;
    ext = {cur, prev};
    a = tap_a(sel);
    b = tap_b(sel);
    pat_miss = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      pat_miss[i] = ext[32 + i] ^ ext[32 + i - a] ^ ext[32 + i - b];
    end
  endfunction

endpackage

// ### verilog/ltsp_sym_if.sv
`timescale 1ns/1ps
interface ltsp_sym_if;
  logic [9:0] symbol;
  logic rd_in;
  logic rd_out;
  logic disparity_error;
  logic code_invalid;
  logic comma;

  modport checker_end (
    input symbol,
    input rd_in,
    output rd_out,
    output disparity_error,
    output code_invalid,
    output comma
  );

  modport user_end (
    output symbol,
    output rd_in,
    input rd_out,
    input disparity_error,
    input code_invalid,
    input comma
  );
endinterface

// ### verilog/ltsp_symbol_check.sv
`timescale 1ns/1ps
module ltsp_symbol_check (
  // Symbol and running disparity
  ltsp_sym_if.checker_end sym
);

  logic [3:0] ones;

  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < ltsp_pkg::SYM_W; i++) begin
      ones = ones + {3'h0, sym.symbol[i]};
    end
  end

  // A symbol is legal only with four, five or six ones.
  assign sym.code_invalid = (ones < ltsp_pkg::ONES_NEG) ||
                            (ones > ltsp_pkg::ONES_POS); // see (RQ8)
  // A positive symbol after positive disparity, or negative after
  // negative, is a running-disparity error.
  assign sym.disparity_error =
    ((ones == ltsp_pkg::ONES_POS) && sym.rd_in) ||
    ((ones == ltsp_pkg::ONES_NEG) && !sym.rd_in); // see (RQ7)
  assign sym.rd_out = (ones == ltsp_pkg::ONES_BAL) ? sym.rd_in :
                      (ones > ltsp_pkg::ONES_BAL);
  assign sym.comma = (sym.symbol[9:3] == ltsp_pkg::COMMA_POS) ||
                     (sym.symbol[9:3] == ltsp_pkg::COMMA_NEG); // see (RQ9)

endmodule // ltsp_symbol_check

// ### verilog/ltsp_lane_top.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) Transmit block high stops transmitted data; low resumes normal words.
// (RQ2) Error inject high corrupts every generated pattern word while held.
// (RQ3) Pattern error flag follows current errors and does not latch.
// (RQ4) Counter clear sets the accumulated pattern error count to zero.
// (RQ5) A 3-bit select picks the pattern the receive checker expects.
// (RQ6) A 3-bit select picks the pattern the transmit generator produces.
// (RQ7) Four flags mark running-disparity errors per received byte.
// (RQ8) Four flags mark received bytes that are no valid line code.
// (RQ9) Comma found rises whenever a comma symbol is received.
// (RQ10) Equaliser reset is pulsed high then low; work starts on release.
// (RQ11) Hold inputs freeze or let adapt the high and low boosts.
// (RQ12) Override inputs choose attribute or signal for each boost.
// (RQ13) Recovery loop freeze holds the clock-recovery state unchanged.
// (RQ14) Driver takes post-emphasis, pre-emphasis and output swing settings.
// (RQ15) A digital monitor bus of 8 or 15 bits is exposed.
// (RQ16) User logic registers controls and synchronises asynchronous status.
module ltsp_lane_top #(
  parameter int MON_W = 15,
  parameter int CNT_W = 32,
  parameter logic [4:0] HIGH_BOOST_ATTR = 5'h08,
  parameter logic [4:0] LOW_BOOST_ATTR = 5'h08
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit path
  input wire logic [31:0] tx_data,
  output logic [31:0] lane0_tx_word,
  // Receive path
  input wire logic [31:0] rx_data,
  input wire logic [39:0] rx_symbols,
  // Asynchronous analogue indications
  input wire logic eq_boost_up,
  input wire logic eq_boost_down,
  input wire logic recovery_early,
  input wire logic recovery_late,
  // Receive status
  output logic lane0_pattern_error_flag,
  output logic [3:0] lane0_byte_disparity_flags,
  output logic [3:0] lane0_byte_code_invalid_flags,
  output logic lane0_comma_found,
  // Analogue controls and monitors
  output logic lane0_equaliser_reset,
  output logic [4:0] lane0_post_emphasis,
  output logic [4:0] lane0_pre_emphasis,
  output logic [3:0] lane0_output_swing,
  output logic [4:0] high_boost_value,
  output logic [4:0] low_boost_value,
  output logic [6:0] lane0_equaliser_monitor,
  output logic [MON_W-1:0] lane0_digital_monitor_bus,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [ltsp_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0] pattern_q;
  logic [19:0] driver_q;
  logic [12:0] boost_sig_q;
  logic [ltsp_pkg::IRQ_W-1:0] irq_status_q;
  logic [ltsp_pkg::IRQ_W-1:0] irq_mask_q;
  logic [ltsp_pkg::IRQ_W-1:0] events;
  logic [CNT_W-1:0] err_count_q;
  logic count_clear_q;
  logic [31:0] read_word;
  logic mapped;
  logic wr_access;
  logic rd_access;
  logic [2:0] gen_sel;
  logic [2:0] chk_sel;
  logic [ltsp_pkg::PHASE_W-1:0] phase_q;
  logic [8:0] live_word;

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign gen_sel = pattern_q[ltsp_pkg::PAT_GEN_LSB +: ltsp_pkg::SEL_W];
  assign chk_sel = pattern_q[ltsp_pkg::PAT_CHK_LSB +: ltsp_pkg::SEL_W];

  always_comb begin
    mapped = 1'b1;
    read_word = 32'h0000_0000;
    case (paddr)
      ltsp_pkg::ADDR_CTRL: begin
        read_word[ltsp_pkg::CTRL_W-1:0] = ctrl_q;
      end
      ltsp_pkg::ADDR_PATTERN: read_word[7:0] = pattern_q;
      ltsp_pkg::ADDR_DRIVER: read_word[19:0] = driver_q;
      ltsp_pkg::ADDR_BOOST: read_word[12:0] = boost_sig_q;
      ltsp_pkg::ADDR_LIVE: read_word[8:0] = live_word;
      ltsp_pkg::ADDR_ERRCNT: read_word[CNT_W-1:0] = err_count_q;
      ltsp_pkg::ADDR_IRQ_STATUS: begin
        read_word[ltsp_pkg::IRQ_W-1:0] = irq_status_q;
      end
      ltsp_pkg::ADDR_IRQ_MASK: begin
        read_word[ltsp_pkg::IRQ_W-1:0] = irq_mask_q;
      end
      ltsp_pkg::ADDR_MONITOR: begin
        read_word[19:0] = {high_boost_value, low_boost_value,
                           3'h0, phase_q};
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      pattern_q <= 8'h00;
      driver_q <= 20'h0_0000;
      boost_sig_q <= 13'h0000;
      irq_mask_q <= '0;
    end else if (wr_access) begin
      case (paddr)
        ltsp_pkg::ADDR_CTRL: begin
          ctrl_q <= pwdata[ltsp_pkg::CTRL_W-1:0];
          ctrl_q[ltsp_pkg::CTRL_CNT_CLEAR] <= 1'b0;
        end
        ltsp_pkg::ADDR_PATTERN: pattern_q <= pwdata[7:0];
        ltsp_pkg::ADDR_DRIVER: driver_q <= pwdata[19:0];
        ltsp_pkg::ADDR_BOOST: boost_sig_q <= pwdata[12:0];
        ltsp_pkg::ADDR_IRQ_MASK: begin
          irq_mask_q <= pwdata[ltsp_pkg::IRQ_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Writing one to the clear bit of CTRL yields a one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_clear_q <= 1'b0;
    end else begin
      count_clear_q <= wr_access && (paddr == ltsp_pkg::ADDR_CTRL) &&
                       pwdata[ltsp_pkg::CTRL_CNT_CLEAR];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // A read clears the sticky bits; a new event in that cycle survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else if (rd_access && paddr == ltsp_pkg::ADDR_IRQ_STATUS) begin
      irq_status_q <= events | (irq_status_q & ~prdata[ltsp_pkg::IRQ_W-1:0]);
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Transmit generator and driver settings
  // ----------------------------------------------------------------
  logic [31:0] tx_hist_q;
  logic [31:0] gen_word;

  assign gen_word = ltsp_pkg::pat_next(tx_hist_q, gen_sel); // see (RQ6)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hist_q <= ltsp_pkg::PATTERN_SEED;
    end else if (ltsp_pkg::pat_valid(gen_sel)) begin
      tx_hist_q <= gen_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane0_tx_word <= ltsp_pkg::RESET_WORD;
    end else if (ctrl_q[ltsp_pkg::CTRL_TX_BLOCK]) begin
      lane0_tx_word <= ltsp_pkg::RESET_WORD; // see (RQ1)
    end else if (ltsp_pkg::pat_valid(gen_sel)) begin
      // Inverting the first bit breaks the recurrence in every word.
      lane0_tx_word <= gen_word ^
        {31'h0000_0000, ctrl_q[ltsp_pkg::CTRL_INJECT]}; // see (RQ2)
    end else begin
      lane0_tx_word <= tx_data;
    end
  end

  assign lane0_post_emphasis =
    driver_q[ltsp_pkg::DRV_POST_LSB +: ltsp_pkg::EMPH_W]; // see (RQ14)
  assign lane0_pre_emphasis =
    driver_q[ltsp_pkg::DRV_PRE_LSB +: ltsp_pkg::EMPH_W]; // see (RQ14)
  assign lane0_output_swing =
    driver_q[ltsp_pkg::DRV_SWING_LSB +: ltsp_pkg::SWING_W]; // see (RQ14)

  // ----------------------------------------------------------------
  // Receive pattern checker
  // ----------------------------------------------------------------
  logic [31:0] rx_prev_q;
  logic word_error;

  assign word_error = ltsp_pkg::pat_valid(chk_sel) &&
    (|ltsp_pkg::pat_miss(rx_prev_q, rx_data, chk_sel)); // see (RQ5)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q <= 32'h0000_0000;
      lane0_pattern_error_flag <= 1'b0;
    end else begin
      rx_prev_q <= rx_data;
      lane0_pattern_error_flag <= word_error; // see (RQ3)
    end
  end

  // An errored word in the clearing cycle is counted after the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_count_q <= '0;
    end else if (count_clear_q) begin
      err_count_q <= {{(CNT_W-1){1'b0}}, word_error}; // see (RQ4)
    end else if (word_error && !(&err_count_q)) begin
      err_count_q <= err_count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Symbol status
  // ----------------------------------------------------------------
  ltsp_sym_if sym_bus [4] ();
  logic [4:0] rd_chain;
  logic [3:0] disp_now;
  logic [3:0] code_now;
  logic [3:0] comma_now;
  logic rd_q;

  assign rd_chain[0] = rd_q;

  for (genvar g = 0; g < 4; g++) begin : g_byte
    assign sym_bus[g].symbol =
      rx_symbols[g*ltsp_pkg::SYM_W +: ltsp_pkg::SYM_W];
    assign sym_bus[g].rd_in = rd_chain[g];
    assign rd_chain[g+1] = sym_bus[g].rd_out;
    assign disp_now[g] = sym_bus[g].disparity_error;
    assign code_now[g] = sym_bus[g].code_invalid;
    assign comma_now[g] = sym_bus[g].comma;
    ltsp_symbol_check u_check (
      .sym(sym_bus[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
      lane0_byte_disparity_flags <= 4'h0;
      lane0_byte_code_invalid_flags <= 4'h0;
      lane0_comma_found <= 1'b0;
    end else begin
      rd_q <= rd_chain[4];
      lane0_byte_disparity_flags <= disp_now; // see (RQ7)
      lane0_byte_code_invalid_flags <= code_now; // see (RQ8)
      lane0_comma_found <= |comma_now; // see (RQ9)
    end
  end

  assign live_word = {lane0_comma_found, lane0_byte_code_invalid_flags,
                      lane0_byte_disparity_flags};
  assign events[ltsp_pkg::IRQ_PATTERN] = lane0_pattern_error_flag;
  assign events[ltsp_pkg::IRQ_DISPARITY] = |lane0_byte_disparity_flags;
  assign events[ltsp_pkg::IRQ_CODE] = |lane0_byte_code_invalid_flags;
  assign events[ltsp_pkg::IRQ_COMMA] = lane0_comma_found;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] async_in;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] steady_q;

  assign async_in = {recovery_late, recovery_early,
                     eq_boost_down, eq_boost_up};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      steady_q <= 4'h0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 4; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          steady_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive equaliser boosts
  // ----------------------------------------------------------------
  logic eq_reset_seen_q;
  logic eq_release;
  logic [4:0] boost_q [2];
  logic [1:0] hold_bit;
  logic [1:0] ovr_bit;
  logic [4:0] attr_val [2];
  logic [4:0] sig_val [2];

  assign lane0_equaliser_reset = ctrl_q[ltsp_pkg::CTRL_EQ_RESET];
  assign eq_release = eq_reset_seen_q && !lane0_equaliser_reset;
  assign hold_bit = {ctrl_q[ltsp_pkg::CTRL_LOW_HOLD],
                     ctrl_q[ltsp_pkg::CTRL_HIGH_HOLD]};
  assign ovr_bit = {ctrl_q[ltsp_pkg::CTRL_LOW_OVR],
                    ctrl_q[ltsp_pkg::CTRL_HIGH_OVR]};
  assign attr_val[0] = HIGH_BOOST_ATTR;
  assign attr_val[1] = LOW_BOOST_ATTR;
  assign sig_val[0] =
    boost_sig_q[ltsp_pkg::BOOST_HIGH_LSB +: ltsp_pkg::BOOST_W];
  assign sig_val[1] =
    boost_sig_q[ltsp_pkg::BOOST_LOW_LSB +: ltsp_pkg::BOOST_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_reset_seen_q <= 1'b0;
    end else begin
      eq_reset_seen_q <= lane0_equaliser_reset;
    end
  end

  for (genvar b = 0; b < 2; b++) begin : g_boost
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        boost_q[b] <= 5'h00;
      end else if (eq_release) begin
        boost_q[b] <= attr_val[b]; // see (RQ10)
      end else if (ovr_bit[b]) begin
        boost_q[b] <= sig_val[b]; // see (RQ12)
      end else if (hold_bit[b] || lane0_equaliser_reset) begin
        boost_q[b] <= boost_q[b]; // see (RQ11)
      end else if (steady_q[0] && !steady_q[1] && !(&boost_q[b])) begin
        boost_q[b] <= boost_q[b] + 5'h01;
      end else if (steady_q[1] && !steady_q[0] && (|boost_q[b])) begin
        boost_q[b] <= boost_q[b] - 5'h01;
      end
    end
  end

  // Without override the boost starts from its attribute value at equaliser reset release; presetn clears it to zero.
  assign high_boost_value = boost_q[0];
  assign low_boost_value = boost_q[1];
  assign lane0_equaliser_monitor = {boost_q[0], boost_q[1][4:3]};

  // ----------------------------------------------------------------
  // Clock recovery loop and monitor
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= '0;
    end else if (ctrl_q[ltsp_pkg::CTRL_FREEZE]) begin
      phase_q <= phase_q; // see (RQ13)
    end else if (steady_q[3] && !steady_q[2]) begin
      phase_q <= phase_q + 7'h01;
    end else if (steady_q[2] && !steady_q[3]) begin
      phase_q <= phase_q - 7'h01;
    end
  end

  logic [14:0] monitor_full;

  assign monitor_full = {phase_q, err_count_q[7:0]};
  assign lane0_digital_monitor_bus = monitor_full[MON_W-1:0]; // see (RQ15)

endmodule // ltsp_lane_top

// ### sim/ltsp_lane_top_chk.sv
`timescale 1ns/1ps
module ltsp_lane_chk #(
  parameter int MON_W = 15
) (
  // Observed top-level ports
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pslverr,
  input logic [31:0] rx_data,
  input logic [39:0] rx_symbols,
  input logic [31:0] lane0_tx_word,
  input logic lane0_pattern_error_flag,
  input logic [3:0] lane0_byte_code_invalid_flags,
  input logic lane0_comma_found,
  input logic lane0_equaliser_reset,
  input logic [3:0] lane0_output_swing,
  input logic [MON_W-1:0] lane0_digital_monitor_bus
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  logic ctl;
  assign wr = psel && penable && pwrite;
  assign ctl = wr && paddr == ltsp_pkg::ADDR_CTRL;
  chk_tx_blocked: assert property (
    ctl && pwdata[0] |=> ##1 lane0_tx_word == 32'h00000000)
    else $error("transmit word not blocked");
  chk_count_cleared: assert property (
    ctl && pwdata[2] |-> ##[2:3] lane0_digital_monitor_bus[7:0] <= 8'h01)
    else $error("error count not cleared");
  chk_flag_release: assert property (
    (rx_data == 32'h00000000) [*2] |=> !lane0_pattern_error_flag)
    else $error("pattern flag held without error");
  chk_code_bad: assert property (
    rx_symbols[19:10] == 10'h000 |=> lane0_byte_code_invalid_flags[1])
    else $error("invalid code not flagged");
  chk_comma_seen: assert property (
    rx_symbols[9:3] == 7'h1F |=> lane0_comma_found)
    else $error("comma not reported");
  chk_eq_reset: assert property (
    ctl |=> lane0_equaliser_reset == $past(pwdata[3]))
    else $error("equaliser reset level wrong");
  chk_swing_set: assert property (
    wr && paddr == ltsp_pkg::ADDR_DRIVER
    |=> lane0_output_swing == $past(pwdata[19:16]))
    else $error("output swing not applied");
  chk_phase_frozen: assert property (
    ctl && pwdata[8] |=> ##1 $stable(lane0_digital_monitor_bus[14:8]) [*4])
    else $error("recovery phase moved while frozen");
  chk_unmapped_err: assert property (
    psel && penable && paddr > ltsp_pkg::ADDR_MONITOR |-> pslverr)
    else $error("unmapped access not refused");
endmodule // ltsp_lane_chk

// ### sim/ltsp_far_end.sv
`timescale 1ns/1ps
module ltsp_far_end (
  // Core clock
  input logic pclk,
  // Line traffic
  input logic [31:0] tx_word,
  input logic [39:0] sym_next,
  output logic [31:0] rx_data,
  output logic [39:0] rx_symbols
);
  // Loopback lets the checker see the generator.
  assign rx_data = tx_word;
  // Symbols are launched on the core clock.
  always_ff @(posedge pclk) begin
    rx_symbols <= sym_next;
  end
endmodule // ltsp_far_end

// ### sim/tb_lane_test_and_status_ports.sv
`timescale 1ns/1ps
module tb_lane_test_and_status_ports;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] tx_data = 32'h00000000;
  logic eq_boost_up = 1'b0;
  logic recovery_late = 1'b0;
  logic [39:0] symv = {4{10'h3E0}};
  logic [31:0] prdata, lane0_tx_word, rx_data, v;
  logic [39:0] rx_symbols;
  logic pready, pslverr, lane0_pattern_error_flag, lane0_comma_found, irq;
  logic [3:0] lane0_byte_disparity_flags, lane0_byte_code_invalid_flags;
  logic [4:0] lane0_post_emphasis, lane0_pre_emphasis;
  logic [4:0] high_boost_value, low_boost_value;
  logic [3:0] lane0_output_swing;
  logic lane0_equaliser_reset;
  logic [14:0] lane0_digital_monitor_bus;
  logic [6:0] eq_mon;
  logic [2:0] s;
  int failures = 0;
  int checks_done = 0;
  logic [39:0] syms [3] = '{{{2{10'h3E0}}, {2{10'h3F0}}},
    {{3{10'h3E0}}, 10'h0F8}, {{2{10'h3E0}}, 10'h000, 10'h3E0}};
  logic [8:0] flags [3] = '{9'h002, 9'h100, 9'h020};

  ltsp_lane_top i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_data, .lane0_tx_word, .rx_data, .rx_symbols,
    .eq_boost_up, .eq_boost_down(1'b0), .recovery_early(1'b0),
    .recovery_late, .lane0_pattern_error_flag, .lane0_byte_disparity_flags,
    .lane0_byte_code_invalid_flags, .lane0_comma_found,
    .lane0_equaliser_reset, .lane0_post_emphasis, .lane0_pre_emphasis,
    .lane0_output_swing, .high_boost_value, .low_boost_value,
    .lane0_equaliser_monitor(eq_mon), .lane0_digital_monitor_bus, .irq
  );
  ltsp_far_end i_far (.pclk, .tx_word(lane0_tx_word), .sym_next(symv),
    .rx_data, .rx_symbols);

  always #12.5 pclk = ~pclk;

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer plus an idle cycle, so no strobe is set twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, v);
    check(v, e);
  endtask

  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(4);
    rd(ltsp_pkg::ADDR_CTRL, 32'h00000000);
    rd(8'h24, 32'h00000000);
    wr(ltsp_pkg::ADDR_DRIVER, 32'h000A1F15);
    check({lane0_output_swing, lane0_pre_emphasis, lane0_post_emphasis},
      {4'hA, 5'h1F, 5'h15});
    tx_data <= 32'h5A5A0F0F;
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000001);
    cyc(1);
    check(lane0_tx_word, 32'h00000000);
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000000);
    cyc(1);
    check(lane0_tx_word, tx_data);
    wr(ltsp_pkg::ADDR_IRQ_MASK, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      s = 3'((i + 5) % 6);
      wr(ltsp_pkg::ADDR_PATTERN, {25'h0, s, 1'b0, s});
      cyc(6);
      repeat (3) begin
        cyc(1);
        check(lane0_pattern_error_flag, 32'h0);
      end
    end
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000002);
    cyc(2);
    check(lane0_pattern_error_flag, 32'h1);
    check(irq, 32'h0);
    wr(ltsp_pkg::ADDR_IRQ_MASK, 32'h00000001);
    check(irq, 32'h1);
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000000);
    cyc(3);
    check(lane0_pattern_error_flag, 32'h0);
    rd(ltsp_pkg::ADDR_IRQ_STATUS, 32'h00000001);
    rd(ltsp_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    check(irq, 32'h0);
    apb(1'b0, ltsp_pkg::ADDR_ERRCNT, 32'h00000000, v);
    check(v != 32'h00000000, 32'h1);
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000004);
    cyc(2);
    rd(ltsp_pkg::ADDR_ERRCNT, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      symv <= syms[i];
      cyc(1);
      symv <= {4{10'h3E0}};
      cyc(2);
      check({lane0_comma_found, lane0_byte_code_invalid_flags,
        lane0_byte_disparity_flags}, flags[i]);
    end
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000158);
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000150);
    eq_boost_up <= 1'b1;
    recovery_late <= 1'b1;
    cyc(12);
    check({high_boost_value, low_boost_value}, {5'h08, 5'h08});
    check(lane0_digital_monitor_bus[14:8], 32'h0);
    wr(ltsp_pkg::ADDR_CTRL, 32'h00000000);
    cyc(12);
    check(high_boost_value > 5'h08, 32'h1);
    check(lane0_digital_monitor_bus[14:8] != 7'h00, 32'h1);
    wr(ltsp_pkg::ADDR_BOOST, 32'h00000A0C);
    wr(ltsp_pkg::ADDR_CTRL, 32'h000000A0);
    cyc(2);
    check({high_boost_value, low_boost_value}, {5'h0C, 5'h0A});
    check(eq_mon, 7'h31);
    eq_boost_up <= 1'b0;
    recovery_late <= 1'b0;
    cyc(2);
    print_verdict();
  end
endmodule // tb_lane_test_and_status_ports

bind ltsp_lane_top ltsp_lane_chk #(.MON_W(MON_W)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .rx_data, .rx_symbols, .lane0_tx_word, .lane0_pattern_error_flag,
  .lane0_byte_code_invalid_flags, .lane0_comma_found,
  .lane0_equaliser_reset, .lane0_output_swing, .lane0_digital_monitor_bus);
